// [pem_consts.vh]
`ifndef PEM_CONSTS_VH
`define PEM_CONSTS_VH
// ------------------------------------------------------------
// register map (word aligned byte addresses)
// ------------------------------------------------------------
`define PEM_ADDR_W 8
`define PEM_OFS_FUNC_SEL 8'h00
`define PEM_OFS_DIR 8'h04
`define PEM_OFS_DATA 8'h08
`define PEM_OFS_MODE 8'h0c
`define PEM_OFS_PIN_IN 8'h10
`define PEM_REG_W 16
`define PEM_BUS_W 32
`define PEM_MODE_W 2
`define PEM_FUNC_SEL_RST 16'h0000
`define PEM_DIR_RST 16'h0000
`define PEM_DATA_RST 16'h0000
// ------------------------------------------------------------
// chip operating modes
// ------------------------------------------------------------
`define PEM_MODE_EXP_ROM_OFF 2'h0
`define PEM_MODE_EXP_ROM_ON 2'h1
`define PEM_MODE_SINGLE 2'h2
// ------------------------------------------------------------
// bus encodings
// ------------------------------------------------------------
`define PEM_HTRANS_NONSEQ_BIT 1
`define PEM_HRESP_OKAY 1'h0
`endif

// [pem_pin_select.v]
`include "pem_consts.vh"

// per-pin function decision, purely combinational
module pem_pin_select (
    input wire [1:0] chipMode,
    input wire [15:0] funcSel,
    output reg [15:0] addrSel
);
    always @* begin
        case (chipMode)
            `PEM_MODE_EXP_ROM_OFF: addrSel = 16'hffff;
            `PEM_MODE_EXP_ROM_ON: addrSel = funcSel;
            `PEM_MODE_SINGLE: addrSel = 16'h0000;
            default: addrSel = 16'h0000;
        endcase
    end
endmodule

// [pem_port_e_mux.v]
`include "pem_consts.vh"

// How it works
// - expanded mode, rom off: all pins are address outputs
// - expanded mode, rom on: each pin selectable, select register honoured
// - single-chip mode: all pins general-purpose, select register ignored
// - select bit n governs only pin n, shared with address line n
// - rom on: bit 0 means general-purpose, bit 1 means address line
// - power-on or hardware standby clears select; watchdog reset keeps it
// - select register kept through software standby and sleep
// - general-purpose pin: direction bit 1 is output, 0 is input
module pem_port_e_mux (
    input wire clk,
    input wire rst_b,
    input wire hwStandby,
    input wire [1:0] chipMode,
    input wire [15:0] addressBus,
    input wire [15:0] padIn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    output reg [15:0] padOut,
    output reg [15:0] padOe,
    output reg [15:0] addrActive
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // per-pin choice: a set select bit takes the first operand
    function [`PEM_REG_W-1:0] pick;
        input [`PEM_REG_W-1:0] sel;
        input [`PEM_REG_W-1:0] whenSet;
        input [`PEM_REG_W-1:0] whenClr;
        begin
            pick = (sel & whenSet) | (~sel & whenClr);
        end
    endfunction

    // one compare for every register offset
    function hit;
        input [`PEM_ADDR_W-1:0] addr;
        input [`PEM_ADDR_W-1:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    // registers sit in the low half of the bus; upper half reads 0
    function [`PEM_BUS_W-1:0] widen;
        input [`PEM_REG_W-1:0] val;
        begin
            widen = {{(`PEM_BUS_W-`PEM_REG_W){1'b0}}, val};
        end
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg [`PEM_REG_W-1:0] funcSel_r;
    reg [`PEM_REG_W-1:0] dir_r;
    reg [`PEM_REG_W-1:0] data_r;
    reg wrPend_r;
    reg [`PEM_ADDR_W-1:0] wrAddr_r;
    reg [`PEM_REG_W-1:0] funcSel_nxt;
    reg [`PEM_REG_W-1:0] dir_nxt;
    reg [`PEM_REG_W-1:0] data_nxt;
    reg [`PEM_REG_W-1:0] padOut_nxt;
    reg [`PEM_REG_W-1:0] padOe_nxt;
    reg [`PEM_BUS_W-1:0] rdNxt;
    wire [`PEM_REG_W-1:0] addrSel;
    wire [`PEM_REG_W-1:0] wrVal;
    wire [`PEM_BUS_W-1:0] modeWord;
    wire accept;
    wire wrFuncSel;
    wire wrDir;
    wire wrData;
    wire [`PEM_ADDR_W-1:0] reqAddr;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // hsize is ignored: every register is one whole word
    assign accept = hsel && hready && htrans[`PEM_HTRANS_NONSEQ_BIT];
    assign reqAddr = haddr[`PEM_ADDR_W-1:0];
    assign wrVal = hwdata[`PEM_REG_W-1:0];
    assign modeWord = {{(`PEM_BUS_W-`PEM_MODE_W){1'b0}}, chipMode};
    assign wrFuncSel = wrPend_r && hit(wrAddr_r, `PEM_OFS_FUNC_SEL);
    assign wrDir = wrPend_r && hit(wrAddr_r, `PEM_OFS_DIR);
    assign wrData = wrPend_r && hit(wrAddr_r, `PEM_OFS_DATA);

    // mode decode kept apart so the per-pin rule sits in one place
    pem_pin_select uSel (
        .chipMode(chipMode),
        .funcSel(funcSel_r),
        .addrSel(addrSel)
    );

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // next values are read so a read right behind a write sees it
    always @* begin
        case (reqAddr)
            `PEM_OFS_FUNC_SEL: rdNxt = widen(funcSel_nxt);
            `PEM_OFS_DIR: rdNxt = widen(dir_nxt);
            `PEM_OFS_DATA: rdNxt = widen(data_nxt);
            `PEM_OFS_MODE: rdNxt = modeWord;
            `PEM_OFS_PIN_IN: rdNxt = widen(padIn);
            default: rdNxt = {`PEM_BUS_W{1'b0}};
        endcase
    end

    // ------------------------------------------------------------
    // ahb-lite slave: zero wait states, write data lands in phase 2
    // ------------------------------------------------------------
    // never stalls and never errors, so both stay constant
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hreadyout <= 1'b1;
            hresp <= `PEM_HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp <= `PEM_HRESP_OKAY;
        end
    end

    // address phase captured; write data only arrives one edge later
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPend_r <= 1'b0;
            wrAddr_r <= {`PEM_ADDR_W{1'b0}};
        end else begin
            wrPend_r <= accept && hwrite;
            if (accept) begin
                wrAddr_r <= reqAddr;
            end
        end
    end

    // read data taken at the address edge, held until the next read
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hrdata <= {`PEM_BUS_W{1'b0}};
        end else if (accept && !hwrite) begin
            hrdata <= rdNxt;
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    // standby wins over a write landing in the same cycle
    always @* begin
        funcSel_nxt = funcSel_r;
        dir_nxt = dir_r;
        data_nxt = data_r;
        if (hwStandby) begin
            funcSel_nxt = `PEM_FUNC_SEL_RST;
            dir_nxt = `PEM_DIR_RST;
            data_nxt = `PEM_DATA_RST;
        end else begin
            if (wrFuncSel) begin
                funcSel_nxt = wrVal;
            end
            if (wrDir) begin
                dir_nxt = wrVal;
            end
            if (wrData) begin
                data_nxt = wrVal;
            end
        end
    end

    // rst_b is the power-on reset; a watchdog reset must not reach it
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            funcSel_r <= `PEM_FUNC_SEL_RST;
            dir_r <= `PEM_DIR_RST;
            data_r <= `PEM_DATA_RST;
        end else begin
            // no sleep or software standby input: contents simply hold
            funcSel_r <= funcSel_nxt;
            dir_r <= dir_nxt;
            data_r <= data_nxt;
        end
    end

    // ------------------------------------------------------------
    // pad drive, registered; one cycle behind the address bus
    // ------------------------------------------------------------
    // address pins always drive, whatever the direction register says
    always @* begin
        padOut_nxt = pick(addrSel, addressBus, data_r);
        padOe_nxt = pick(addrSel, {`PEM_REG_W{1'b1}}, dir_r);
    end

    // registered so pads never glitch while the mode settles
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            padOut <= {`PEM_REG_W{1'b0}};
            padOe <= {`PEM_REG_W{1'b0}};
            addrActive <= {`PEM_REG_W{1'b0}};
        end else begin
            addrActive <= addrSel;
            padOut <= padOut_nxt;
            padOe <= padOe_nxt;
        end
    end
endmodule

// [pem_port_e_mux_properties.sv]
module pem_mux_props (
    input wire clk, input wire rst_b, input wire hwStandby, input wire hsel,
    input wire [1:0] chipMode, input wire [15:0] addressBus,
    input wire hreadyout, input wire hresp, input wire [15:0] padOut,
    input wire [15:0] padOe, input wire [15:0] addrActive
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence sClr; hwStandby ##1 chipMode == 2'h1; endsequence
    sequence sQuiet; !hsel && !hwStandby && $stable(chipMode); endsequence
    AST_ROM_OFF: assert property (chipMode == 2'h0 |=> &addrActive)
        else $error("rom off pin not address");
    AST_SINGLE: assert property (chipMode == 2'h2 |=> !(|addrActive))
        else $error("single chip pin is address");
    AST_MODE3: assert property (chipMode == 2'h3 |=> !(|addrActive))
        else $error("mode three pin is address");
    AST_FOLLOW: assert property (
        ((padOut ^ $past(addressBus)) & addrActive) == 16'h0)
        else $error("address pin not following bus");
    AST_DRIVE: assert property ((addrActive & ~padOe) == 16'h0)
        else $error("address pin not driven");
    AST_CLEAR: assert property (sClr |=> addrActive == 16'h0)
        else $error("standby left select set");
    AST_QUIET: assert property (sQuiet [*3] |=> $stable(addrActive))
        else $error("select changed with no cause");
    AST_OKAY: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
endmodule
bind pem_port_e_mux pem_mux_props props_u (.*);

// [pem_ext_side.sv]
module pem_ext_side (
    input wire [15:0] padOut,
    input wire [15:0] padOe,
    input wire [15:0] extDrv,
    output logic [15:0] padIn
);
    // far side drives only pins that the chip leaves as inputs
    assign padIn = (padOe & padOut) | (~padOe & extDrv);
endmodule

// [pem_port_e_mux_tb.sv]
module pem_port_e_mux_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_b = 1'b0, hwStandby = 1'b0, hsel = 1'b0;
    logic hwrite = 1'b0, hreadyout, hresp;
    logic [1:0] chipMode = 2'h2, htrans = 2'h0;
    logic [15:0] addressBus = 16'h5a3c, extDrv = 16'h0, padIn;
    logic [15:0] padOut, padOe, addrActive;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    int n_mismatch = 0, checks_done = 0, cyc = 0;
    always #4 clk = ~clk;
    pem_port_e_mux dut_u (
        .clk(clk),
        .rst_b(rst_b),
        .hwStandby(hwStandby),
        .chipMode(chipMode),
        .addressBus(addressBus),
        .padIn(padIn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(3'h2),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .padOut(padOut),
        .padOe(padOe),
        .addrActive(addrActive)
    );
    pem_ext_side part_u (
        .padOut(padOut),
        .padOe(padOe),
        .extDrv(extDrv),
        .padIn(padIn)
    );
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic settle;
        repeat (3) @(posedge clk);
    endtask
    task automatic t_modes;
        logic [15:0] e [4] = '{16'hffff, 16'h8001, 16'h0, 16'h0};
        bus(0, 32'h0, 32'h0);
        chk(rd, 32'h0);
        bus(1, 32'h0, 32'hffff8001);
        for (int m = 0; m < 4; m++) begin
            chipMode <= m[1:0];
            addressBus <= ~addressBus;
            settle();
            chk(addrActive, e[m]);
            chk(padOe, e[m]);
            chk(padOut & e[m], addressBus & e[m]);
            bus(0, 32'h0, 32'h0);
            chk(rd, 32'h8001);
        end
    endtask
    task automatic t_gpio;
        chipMode <= 2'h2;
        extDrv <= 16'hc300;
        bus(1, 32'h4, 32'h00ff);
        bus(1, 32'h8, 32'h00a5);
        settle();
        chk(padOe, 32'h00ff);
        bus(0, 32'h10, 32'h0);
        chk(rd, 32'hc3a5);
        bus(0, 32'h20, 32'h0);
        chk(rd, 32'h0);
    endtask
    task automatic t_clear;
        chipMode <= 2'h1;
        bus(1, 32'h0, 32'h1234);
        hwStandby <= 1;
        @(posedge clk);
        hwStandby <= 0;
        settle();
        chk(addrActive, 32'h0);
        bus(0, 32'h0, 32'h0);
        chk(rd, 32'h0);
        bus(0, 32'h4, 32'h0);
        chk(rd, 32'h0);
    endtask
    task automatic t_reset;
        chipMode <= 2'h1;
        bus(1, 32'h0, 32'h00ff);
        settle();
        chk(addrActive, 32'h00ff);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        chk(addrActive, 32'h0);
        rst_b <= 1'b1;
        bus(0, 32'h0, 32'h0);
        chk(rd, 32'h0);
        bus(1, 32'h0, 32'h0f0f);
        settle();
        chk(addrActive, 32'h0f0f);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            summarize();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1;
        t_modes();
        t_gpio();
        t_clear();
        t_reset();
        summarize();
    end
endmodule
